// >>> design/uim_top.sv
// Chosen here: the APB slave port.
`timescale 1ns/1ps
module uim_top (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire uim_pkg::uim_addr_t paddr,
    input  wire uim_pkg::uim_data_t pwdata,
    input  wire logic [3:0]        pstrb,
    output uim_pkg::uim_data_t     prdata,
    output logic                   pready,
    output logic                   pslverr,
    output logic                   irq,
    input  wire logic              autobaud_timeout_evt,
    input  wire logic              autobaud_end_evt,
    input  wire logic              busy_evt,
    input  wire logic              char_timeout_evt,
    input  wire logic              modem_status_evt,
    input  wire logic              line_status_evt,
    input  wire logic              tx_empty_evt,
    input  wire logic              rx_avail_evt
);
    import uim_pkg::*;

    logic      capture;
    logic      fire;
    logic      wr_lane0;
    uim_src_t  src_evt;
    uim_src_t  raw_r;
    uim_src_t  mask_r;
    uim_src_t  mask_nxt;
    uim_src_t  en_wr;
    uim_src_t  dis_wr;
    uim_src_t  clr_wr;
    uim_src_t  masked;
    uim_data_t prdata_r;
    uim_data_t rd_nxt;
    logic      pslverr_r;
    logic      err_nxt;
    logic      irq_r;
    logic      pready_r;
    logic      addr_ok;

    uim_apb_slave u_apb (
        .pclk     (pclk),
        .presetn  (presetn),
        .psel     (psel),
        .penable  (penable),
        .pready_r (pready_r),
        .capture  (capture),
        .fire     (fire)
    );

    always_comb begin
        src_evt = '0;
        src_evt[BIT_AUTOBAUD_TIMEOUT] = autobaud_timeout_evt;
        src_evt[BIT_AUTOBAUD_END]     = autobaud_end_evt;
        src_evt[BIT_BUSY]             = busy_evt;
        src_evt[BIT_CHAR_TIMEOUT]     = char_timeout_evt;
        src_evt[BIT_MODEM_STATUS]     = modem_status_evt;
        src_evt[BIT_LINE_STATUS]      = line_status_evt;
        src_evt[BIT_TX_EMPTY]         = tx_empty_evt;
        src_evt[BIT_RX_AVAIL]         = rx_avail_evt;
    end

    // only byte lane 0 carries live bits; upper lanes are reserved
    assign wr_lane0 = fire && pwrite && pstrb[0];

    always_comb begin
        en_wr  = '0;
        dis_wr = '0;
        clr_wr = '0;
        if (wr_lane0 && uim_hit(paddr, OFF_ENABLE)) begin
            en_wr = pwdata[NSRC-1:0];
        end
        if (wr_lane0 && uim_hit(paddr, OFF_DISABLE)) begin
            dis_wr = pwdata[NSRC-1:0];
        end
        if (wr_lane0 && uim_hit(paddr, OFF_STATCLR)) begin
            clr_wr = pwdata[NSRC-1:0];
        end
    end

    uim_flag_bank u_flags (
        .pclk    (pclk),
        .presetn (presetn),
        .set_evt (src_evt),
        .clr_req (clr_wr),
        .flags_r (raw_r)
    );

    // bit i of the disable write clears enable i; zeros leave it alone
    // and a disable always overrides an enable of the same bit
    assign mask_nxt = (mask_r | en_wr) & ~dis_wr;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask_r <= MASK_RST;
        end else begin
            mask_r <= mask_nxt;
        end
    end

    assign masked = raw_r & mask_r;

    // the five live offsets; anything else answers with pslverr
    assign addr_ok = uim_hit(paddr, OFF_ENABLE) ||
                     uim_hit(paddr, OFF_DISABLE) ||
                     uim_hit(paddr, OFF_MASK) ||
                     uim_hit(paddr, OFF_RAW) ||
                     uim_hit(paddr, OFF_STATCLR);

    // read data is taken in the first access cycle and held to pready
    always_comb begin
        rd_nxt  = PRDATA_RST;
        err_nxt = 1'b0;
        if (uim_hit(paddr, OFF_MASK)) begin
            rd_nxt[NSRC-1:0] = mask_r;
        end else if (uim_hit(paddr, OFF_RAW)) begin
            rd_nxt[NSRC-1:0] = raw_r;
        end else if (uim_hit(paddr, OFF_STATCLR)) begin
            rd_nxt[NSRC-1:0] = masked;
        end else if (!uim_hit(paddr, OFF_ENABLE) &&
                     !uim_hit(paddr, OFF_DISABLE)) begin
            err_nxt = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r <= PRDATA_RST;
        end else if (capture) begin
            prdata_r <= pwrite ? PRDATA_RST : rd_nxt;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pslverr_r <= 1'b0;
        end else if (capture) begin
            pslverr_r <= err_nxt;
        end else if (fire) begin
            pslverr_r <= 1'b0;
        end
    end

    // registered so the pin is glitch free; costs one cycle of latency
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= |masked;
        end
    end

    assign prdata  = prdata_r;
    assign pready  = pready_r;
    assign pslverr = pslverr_r;
    assign irq     = irq_r;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    genvar gi;
    generate
        for (gi = 0; gi < NSRC; gi++) begin : g_chk
            disable_bit_a:
                assert property (wr_lane0 && uim_hit(paddr, OFF_DISABLE)
                    && pwdata[gi] |=> !mask_r[gi])
                else $error("disable write left enable bit set");
            enable_bit_a:
                assert property (wr_lane0 && uim_hit(paddr, OFF_ENABLE)
                    && pwdata[gi] |=> mask_r[gi])
                else $error("enable write did not set enable bit");
            mask_set_only_a:
                assert property (!mask_r[gi] && !en_wr[gi] |=> !mask_r[gi])
                else $error("enable bit set without enable write");
            mask_clear_only_a:
                assert property (mask_r[gi] && !dis_wr[gi] |=> mask_r[gi])
                else $error("enable bit cleared without disable write");
            evt_sets_raw_a:
                assert property (src_evt[gi] |=> raw_r[gi])
                else $error("event did not set raw flag");
            raw_sticky_a:
                assert property (!src_evt[gi] && !clr_wr[gi]
                    |=> $stable(raw_r[gi]))
                else $error("raw flag changed without event or clear");
            status_clear_a:
                assert property (clr_wr[gi] && !src_evt[gi] |=> !raw_r[gi])
                else $error("write-one clear left raw flag set");
        end
    endgenerate

    mask_read_a:
        assert property (fire && !pwrite && uim_hit(paddr, OFF_MASK)
            |-> prdata_r[NSRC-1:0] == mask_r)
        else $error("mask status read mismatch");

    mask_ro_a:
        assert property (wr_lane0 && uim_hit(paddr, OFF_MASK) |=>
            $stable(mask_r))
        else $error("write to mask status changed mask");

    mask_reset_a:
        assert property (!$past(presetn) |-> mask_r == MASK_RST)
        else $error("mask not cleared by reset");

    reserved_zero_a:
        assert property (fire && !pwrite |->
            prdata_r[DATA_W-1:NSRC] == '0)
        else $error("reserved read bits not zero");

    raw_read_a:
        assert property (fire && !pwrite && uim_hit(paddr, OFF_RAW)
            |-> prdata_r[NSRC-1:0] == $past(raw_r))
        else $error("raw status read mismatch");

    status_read_a:
        assert property (fire && !pwrite && uim_hit(paddr, OFF_STATCLR)
            |-> prdata_r[NSRC-1:0] == $past(raw_r & mask_r))
        else $error("masked status read mismatch");

    mask_hold_a:
        assert property (en_wr == '0 && dis_wr == '0 |=> $stable(mask_r))
        else $error("mask changed without enable or disable");

    irq_follow_a:
        assert property (1'b1 |=> irq_r == $past(|(raw_r & mask_r)))
        else $error("interrupt output does not follow masked flags");

    irq_masked_a:
        assert property (mask_r == '0 |=> !irq_r)
        else $error("interrupt raised with every source masked");

    err_unmapped_a:
        assert property (fire && !uim_hit(paddr, OFF_ENABLE)
            && !uim_hit(paddr, OFF_DISABLE) && !uim_hit(paddr, OFF_MASK)
            && !uim_hit(paddr, OFF_RAW) && !uim_hit(paddr, OFF_STATCLR)
            |-> pslverr_r)
        else $error("unmapped access without pslverr");

    err_mapped_a:
        assert property (fire && addr_ok |-> !pslverr_r)
        else $error("pslverr on a mapped address");

    err_pulse_a:
        assert property (pslverr_r |-> pready_r)
        else $error("pslverr without pready");

    setup_quiet_a:
        assert property (psel && !penable |-> !pready_r)
        else $error("pready high in a setup cycle");

    prdata_hold_a:
        assert property (!capture |=> $stable(prdata_r))
        else $error("read data changed outside capture");

    write_rdata_a:
        assert property (fire && pwrite |-> prdata_r == '0)
        else $error("read data not zero on a write");

    wo_read_zero_a:
        assert property (fire && !pwrite && (uim_hit(paddr, OFF_ENABLE)
            || uim_hit(paddr, OFF_DISABLE)) |-> prdata_r == '0)
        else $error("write-only register read not zero");

    read_no_effect_a:
        assert property (fire && !pwrite |=> $stable(mask_r))
        else $error("read changed the mask");

    unmapped_write_a:
        assert property (fire && pwrite && !addr_ok |=> $stable(mask_r))
        else $error("unmapped write changed the mask");

    strobe_off_a:
        assert property (fire && pwrite && !pstrb[0] |=> $stable(mask_r))
        else $error("write without lane 0 changed the mask");

    resv_write_a:
        assert property (wr_lane0 && uim_hit(paddr, OFF_ENABLE)
            && pwdata[NSRC-1:0] == '0 |=> $stable(mask_r))
        else $error("reserved enable bits changed the mask");

    raw_ro_a:
        assert property (wr_lane0 && uim_hit(paddr, OFF_RAW)
            && src_evt == '0 |=> $stable(raw_r))
        else $error("write to raw status changed raw flags");

    stat_write_mask_a:
        assert property (wr_lane0 && uim_hit(paddr, OFF_STATCLR)
            |=> $stable(mask_r))
        else $error("status clear write changed the mask");

    read_raw_keep_a:
        assert property (fire && !pwrite && src_evt == '0
            |=> $stable(raw_r))
        else $error("read changed raw flags");

    irq_source_a:
        assert property ((raw_r & mask_r) != '0 |=> irq_r)
        else $error("enabled raw flag did not raise interrupt");

    irq_clear_a:
        assert property ((raw_r & mask_r) == '0 |=> !irq_r)
        else $error("interrupt high with no enabled raw flag");

    disable_cov_c: cover property (wr_lane0 && dis_wr != '0 ##1
        mask_r == '0);
    raw_read_cov_c: cover property (fire && !pwrite &&
        uim_hit(paddr, OFF_RAW));
    irq_rise_cov_c: cover property (!irq_r ##1 irq_r);
    clear_race_cov_c: cover property ((clr_wr & src_evt) != '0);
    enable_cov_c: cover property (wr_lane0 && en_wr != '0);
endmodule : uim_top

// >>> design/uim_pkg.sv
// What this block does
// - disable bit 7 clears autobaud timeout enable
// - disable bit 6 clears autobaud end enable
// - disable bit 5 clears busy enable
// - disable bit 4 clears character timeout enable
// - disable bit 3 clears modem status enable
// - disable bit 2 clears line status enable
// - disable bit 1 clears transmit empty enable
// - disable bit 0 clears receive available enable
// - mask status is read-only, one means enabled
// - all mask bits read zero after reset
// - bits 31 to 8 read zero, writes ignored
// - raw status register shows eight unmasked flags
// - enable register writes one to set mask
// - masked status is raw gated; write-one clears
// - raw transmit empty resets one, others zero
package uim_pkg;
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned NSRC   = 8;

    typedef logic [NSRC-1:0]   uim_src_t;
    typedef logic [ADDR_W-1:0] uim_addr_t;
    typedef logic [DATA_W-1:0] uim_data_t;

    localparam uim_addr_t OFF_ENABLE  = 8'h20;
    localparam uim_addr_t OFF_DISABLE = 8'h24;
    localparam uim_addr_t OFF_MASK    = 8'h28;
    localparam uim_addr_t OFF_RAW     = 8'h2C;
    localparam uim_addr_t OFF_STATCLR = 8'h30;

    localparam int unsigned BIT_AUTOBAUD_TIMEOUT = 7;
    localparam int unsigned BIT_AUTOBAUD_END     = 6;
    localparam int unsigned BIT_BUSY             = 5;
    localparam int unsigned BIT_CHAR_TIMEOUT     = 4;
    localparam int unsigned BIT_MODEM_STATUS     = 3;
    localparam int unsigned BIT_LINE_STATUS      = 2;
    localparam int unsigned BIT_TX_EMPTY         = 1;
    localparam int unsigned BIT_RX_AVAIL         = 0;

    localparam uim_src_t  MASK_RST   = 8'h00;
    localparam uim_src_t  RAW_RST    = 8'h02;
    localparam uim_data_t PRDATA_RST = 32'h0000_0000;

    typedef enum logic [1:0] {
        UIM_IDLE = 2'b01,
        UIM_RESP = 2'b10
    } uim_state_e;

    function automatic logic uim_hit(input uim_addr_t a,
                                     input uim_addr_t off);
        return a == off;
    endfunction : uim_hit
endpackage : uim_pkg

// >>> design/uim_apb_slave.sv
`timescale 1ns/1ps
module uim_apb_slave (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic psel,
    input  wire logic penable,
    output logic      pready_r,
    output logic      capture,
    output logic      fire
);
    import uim_pkg::*;

    uim_state_e state_r;
    uim_state_e state_nxt;

    // one wait state: read data is registered before pready rises
    assign capture = (state_r == UIM_IDLE) && psel && penable;
    assign fire    = psel && penable && pready_r;

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            UIM_IDLE: if (capture) state_nxt = UIM_RESP;
            UIM_RESP: state_nxt = UIM_IDLE;
            default:  state_nxt = UIM_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= UIM_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r <= 1'b0;
        end else begin
            pready_r <= capture;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    ready_pulse_a: assert property (pready_r |=> !pready_r)
        else $error("pready held longer than one cycle");
    ready_after_a: assert property (capture |=> pready_r)
        else $error("pready did not follow access phase");
endmodule : uim_apb_slave

// >>> design/uim_flag_bank.sv
`timescale 1ns/1ps
module uim_flag_bank (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire uim_pkg::uim_src_t set_evt,
    input  wire uim_pkg::uim_src_t clr_req,
    output uim_pkg::uim_src_t     flags_r
);
    import uim_pkg::*;

    genvar i;
    generate
        for (i = 0; i < NSRC; i++) begin : g_flag
            // a new event in the clearing cycle must not be lost
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    flags_r[i] <= RAW_RST[i];
                end else if (set_evt[i]) begin
                    flags_r[i] <= 1'b1;
                end else if (clr_req[i]) begin
                    flags_r[i] <= 1'b0;
                end
            end
        end
    endgenerate

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    set_wins_a: assert property ((set_evt & clr_req) != '0 |=>
        (flags_r & $past(set_evt & clr_req)) == $past(set_evt & clr_req))
        else $error("event lost against a clear");
    clear_works_a: assert property ((clr_req & ~set_evt) != '0 |=>
        (flags_r & $past(clr_req & ~set_evt)) == '0)
        else $error("write-one clear did not clear flag");
    raw_reset_a: assert property (!$past(presetn) |->
        flags_r == RAW_RST)
        else $error("raw flags wrong after reset");
endmodule : uim_flag_bank

// >>> bench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import uim_pkg::*;

    logic      pclk;
    logic      presetn;
    logic      psel;
    logic      penable;
    logic      pwrite;
    uim_addr_t paddr;
    uim_data_t pwdata;
    logic [3:0] pstrb;
    uim_data_t prdata;
    logic      pready;
    logic      pslverr;
    logic      irq;
    uim_src_t  evt;
    int        n_errors;
    int        n_checks;
    uim_data_t rd;
    logic      err;

    uim_top DUT (
        .pclk                 (pclk),
        .presetn              (presetn),
        .psel                 (psel),
        .penable              (penable),
        .pwrite               (pwrite),
        .paddr                (paddr),
        .pwdata               (pwdata),
        .pstrb                (pstrb),
        .prdata               (prdata),
        .pready               (pready),
        .pslverr              (pslverr),
        .irq                  (irq),
        .autobaud_timeout_evt (evt[7]),
        .autobaud_end_evt     (evt[6]),
        .busy_evt             (evt[5]),
        .char_timeout_evt     (evt[4]),
        .modem_status_evt     (evt[3]),
        .line_status_evt      (evt[2]),
        .tx_empty_evt         (evt[1]),
        .rx_avail_evt         (evt[0])
    );

    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end

    task automatic end_of_test;
        if (n_errors == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : end_of_test

    task automatic chk(input string nm, input uim_data_t exp,
                       input uim_data_t got);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task automatic tick(input int n);
        repeat (n) @(posedge pclk);
    endtask : tick

    // request held until pready is seen high at a rising edge
    task automatic apb(input logic wr, input uim_addr_t a,
                       input uim_data_t d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // no wait limit here; a hang is left to the watchdog
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rchk(input string nm, input uim_addr_t a,
                        input uim_data_t exp);
        apb(1'b0, a, 32'h0000_0000);
        chk(nm, exp, rd);
        chk({nm, "_err"}, 32'h0000_0000, {31'h0, err});
    endtask : rchk

    task automatic s_reset;
        rchk("mask_rst", OFF_MASK, 32'h0000_0000);
        rchk("raw_rst", OFF_RAW, 32'h0000_0002);
        rchk("stat_rst", OFF_STATCLR, 32'h0000_0000);
        chk("irq_rst", 32'h0, {31'h0, irq});
    endtask : s_reset

    task automatic s_mask;
        uim_data_t m;
        m = 32'h0000_00FF;
        apb(1'b1, OFF_ENABLE, m);
        rchk("mask_en", OFF_MASK, m);
        for (int i = 7; i >= 0; i--) begin
            m[i] = 1'b0;
            apb(1'b1, OFF_DISABLE, 32'h1 << i);
            rchk("mask_dis", OFF_MASK, m);
        end
        apb(1'b1, OFF_ENABLE, 32'h0000_0055);
        apb(1'b1, OFF_DISABLE, 32'h0000_0000);
        rchk("mask_keep", OFF_MASK, 32'h0000_0055);
        apb(1'b1, OFF_MASK, 32'h0000_00AA);
        rchk("mask_ro", OFF_MASK, 32'h0000_0055);
        apb(1'b1, OFF_DISABLE, 32'hFFFF_FF00);
        apb(1'b1, OFF_ENABLE, 32'hFFFF_FF00);
        rchk("mask_resv", OFF_MASK, 32'h0000_0055);
        pstrb <= 4'hE;
        apb(1'b1, OFF_ENABLE, 32'h0000_00AA);
        pstrb <= 4'hF;
        rchk("mask_strb", OFF_MASK, 32'h0000_0055);
        apb(1'b1, OFF_DISABLE, 32'h0000_00FF);
    endtask : s_mask

    task automatic s_irq;
        tick(3);
        chk("irq_masked", 32'h0, {31'h0, irq});
        apb(1'b1, OFF_ENABLE, 32'h0000_0002);
        tick(2);
        chk("irq_on", 32'h1, {31'h0, irq});
        rchk("stat_tx", OFF_STATCLR, 32'h0000_0002);
        apb(1'b1, OFF_STATCLR, 32'h0000_0002);
        rchk("raw_clr", OFF_RAW, 32'h0000_0000);
        tick(2);
        chk("irq_off", 32'h0, {31'h0, irq});
    endtask : s_irq

    // each source in turn: raw flag, gated status, irq, clear
    task automatic s_events;
        apb(1'b1, OFF_DISABLE, 32'h0000_00FF);
        apb(1'b1, OFF_ENABLE, 32'h0000_00F0);
        for (int i = 0; i < 8; i++) begin
            @(posedge pclk);
            evt <= uim_src_t'(8'h01 << i);
            @(posedge pclk);
            evt <= 8'h00;
            rchk("raw_evt", OFF_RAW, 32'h1 << i);
            rchk("stat_evt", OFF_STATCLR,
                 (i >= 4) ? (32'h1 << i) : 32'h0);
            chk("irq_evt", (i >= 4) ? 32'h1 : 32'h0,
                {31'h0, irq});
            apb(1'b1, OFF_STATCLR, 32'h1 << i);
            rchk("raw_evclr", OFF_RAW, 32'h0);
        end
    endtask : s_events

    task automatic s_unmapped;
        apb(1'b0, 8'h40, 32'h0000_0000);
        chk("unmap_rd", 32'h0, rd);
        chk("unmap_err", 32'h1, {31'h0, err});
    endtask : s_unmapped

    initial begin
        n_errors = 0;
        n_checks = 0;
        presetn  = 1'b0;
        psel     = 1'b0;
        penable  = 1'b0;
        pwrite   = 1'b0;
        paddr    = 8'h00;
        pwdata   = 32'h0000_0000;
        pstrb    = 4'hF;
        evt      = 8'h00;
        tick(3);
        presetn <= 1'b1;
        tick(1);
        s_reset();
        s_mask();
        s_irq();
        s_events();
        s_unmapped();
        tick(2);
        end_of_test();
    end

    // whole run is a few hundred cycles; this is far beyond it
    initial begin
        #(8 * 20000);
        n_errors++;
        end_of_test();
    end
endmodule : tb_top
